// ===== hdl/hdrp_pkg.sv
package hdrp_pkg;

    // fixed target address of the register port
    localparam logic [6:0] SLAVE_ADDR   = 7'h5A;

    // bit positions inside one byte frame: bits 0..7, then the ack slot
    localparam logic [3:0] CNT_FIRST    = 4'h1;
    localparam logic [3:0] CNT_LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_ACK      = 4'h8;
    localparam logic [2:0] MSB_POS      = 3'h7;

    // reset values
    localparam logic [3:0] CNT_RST      = 4'h0;
    localparam logic [7:0] BYTE_RST     = 8'h00;
    localparam logic [7:0] PTR_RST      = 8'h00;

    // byte sent when the prefetch has not come back in time
    localparam logic [7:0] FILL_BYTE    = 8'hFF;

    // link-side frame states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } hdrp_state_type;

endpackage : hdrp_pkg

// ===== hdl/hdrp_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for a level or toggle
module hdrp_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);

    logic meta;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : hdrp_sync

// ===== hdl/hdrp_port.sv
// Summary of operation
// - bytes are eight bits, most significant bit first on the wire
// - the receiver answers every byte with one acknowledge bit
// - sda falling with scl high starts; sda rising with scl high stops
// - data on sda only changes while scl is low
// - transfer opens with 7-bit address plus direction; only ours answers
// - acknowledge holds sda low for the whole ack clock
// - sda and scl are open drain; never driven high (port only pulls sda low; the sim master drives scl high)
// - no limit on bytes between start and stop
// - single and multi-byte reads and writes work on every register
// - first write byte sets pointer; later bytes go to consecutive regs
// - ack our address byte, then ack the pointer byte
// - ack every data byte of a multi-byte write
// - read returns bytes from the pointer on while master acks
// - on master nack the port releases sda and stops sending
`timescale 1ns/1ps

module hdrp_port (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            reg_wr,
    output logic [7:0]      reg_wr_addr,
    output logic [7:0]      reg_wr_data,
    output logic            reg_rd,
    output logic [7:0]      reg_rd_addr,
    input  wire logic [7:0] reg_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    hdrp_pkg::hdrp_state_type state;

    logic       start_tgl;
    logic       stop_tgl;
    logic       start_seen;
    logic       stop_seen;
    logic       start_hit;
    logic       stop_hit;
    logic [3:0] cnt;
    logic [6:0] shift;
    logic [7:0] rx_byte;
    logic       ack_pend;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic       sda_drv_low;
    logic [2:0] bit_sel;

    // link to system crossing words, held stable between toggles
    logic       wr_tgl;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       req_tgl;
    logic [7:0] req_addr;

    // system side
    logic       wr_tgl_s;
    logic       wr_seen;
    logic       req_tgl_s;
    logic       req_seen;
    logic       rd_ack_tgl;
    logic [7:0] rd_hold;

    // back into the link domain
    logic       rd_ack_s;
    logic       rd_ready;

    ////////////////////////////////////////////////////////////////////////
    // start and stop detection, clocked by sda itself

    // scl never moves during these, so sampling it here is safe
    always_ff @(negedge sda_in or posedge rst) begin
        if (rst) begin
            start_tgl <= 1'b0;
        end else if (scl) begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge sda_in or posedge rst) begin
        if (rst) begin
            stop_tgl <= 1'b0;
        end else if (scl) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    // a toggle not yet seen by the scl side marks a fresh event
    assign start_hit = start_tgl ^ start_seen;
    assign stop_hit  = stop_tgl ^ stop_seen;
    assign rx_byte   = {shift, sda_in};

    ////////////////////////////////////////////////////////////////////////
    // link domain: receive side, sampled on rising scl

    // frame sequencing; no byte counter, so frames run unbounded
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            state      <= hdrp_pkg::ST_IDLE;
            cnt        <= hdrp_pkg::CNT_RST;
            shift      <= '0;
            ack_pend   <= 1'b0;
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
        end else begin
            start_seen <= start_tgl;
            stop_seen  <= stop_tgl;
            if (start_hit) begin
                // first address bit arrives on this very edge
                state    <= hdrp_pkg::ST_ADDR;
                cnt      <= hdrp_pkg::CNT_FIRST;
                shift    <= {6'h00, sda_in};
                ack_pend <= 1'b0;
            end else if (stop_hit) begin
                state    <= hdrp_pkg::ST_IDLE;
                cnt      <= hdrp_pkg::CNT_RST;
                ack_pend <= 1'b0;
            end else if (cnt < hdrp_pkg::CNT_LAST_BIT) begin
                shift <= {shift[5:0], sda_in};
                cnt   <= cnt + 4'h1;
            end else if (cnt == hdrp_pkg::CNT_LAST_BIT) begin
                cnt      <= hdrp_pkg::CNT_ACK;
                ack_pend <= 1'b0;
                unique case (state)
                    hdrp_pkg::ST_ADDR: begin
                        if (rx_byte[7:1] == hdrp_pkg::SLAVE_ADDR) begin
                            ack_pend <= 1'b1;
                            // direction bit picks the phase
                            if (rx_byte[0]) begin
                                state <= hdrp_pkg::ST_RDATA;
                            end else begin
                                state <= hdrp_pkg::ST_PTR;
                            end
                        end else begin
                            state <= hdrp_pkg::ST_IGNORE;
                        end
                    end
                    hdrp_pkg::ST_PTR: begin
                        ack_pend <= 1'b1;
                        state    <= hdrp_pkg::ST_WDATA;
                    end
                    hdrp_pkg::ST_WDATA: begin
                        ack_pend <= 1'b1;
                    end
                    hdrp_pkg::ST_IDLE,
                    hdrp_pkg::ST_RDATA,
                    hdrp_pkg::ST_IGNORE: begin
                        ack_pend <= 1'b0;
                    end
                endcase
            end else begin
                cnt      <= hdrp_pkg::CNT_RST;
                ack_pend <= 1'b0;
                // master nack ends our sending until the next start
                if (state == hdrp_pkg::ST_RDATA && sda_in) begin
                    state <= hdrp_pkg::ST_IGNORE;
                end
            end
        end
    end

    // pointer, write posting and read prefetch
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            ptr      <= hdrp_pkg::PTR_RST;
            wr_tgl   <= 1'b0;
            wr_addr  <= hdrp_pkg::BYTE_RST;
            wr_data  <= hdrp_pkg::BYTE_RST;
            req_tgl  <= 1'b0;
            req_addr <= hdrp_pkg::PTR_RST;
            tx       <= hdrp_pkg::BYTE_RST;
        end else if (!start_hit && !stop_hit) begin
            if (cnt == hdrp_pkg::CNT_LAST_BIT
                && state == hdrp_pkg::ST_PTR) begin
                ptr      <= rx_byte;
                req_addr <= rx_byte;
                req_tgl  <= ~req_tgl;
            end else if (cnt == hdrp_pkg::CNT_LAST_BIT
                         && state == hdrp_pkg::ST_WDATA) begin
                wr_addr  <= ptr;
                wr_data  <= rx_byte;
                wr_tgl   <= ~wr_tgl;
                ptr      <= ptr + 8'h01;
                req_addr <= ptr + 8'h01;
                req_tgl  <= ~req_tgl;
            end else if (cnt == hdrp_pkg::CNT_ACK
                         && state == hdrp_pkg::ST_RDATA && !sda_in) begin
                // next byte was fetched a whole byte time ago
                tx       <= rd_ready ? rd_hold : hdrp_pkg::FILL_BYTE;
                ptr      <= ptr + 8'h01;
                req_addr <= ptr + 8'h01;
                req_tgl  <= ~req_tgl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: drive side, updated on falling scl

    assign bit_sel = hdrp_pkg::MSB_POS - cnt[2:0];

    // changing only on the falling edge keeps sda still while scl is high
    always_ff @(negedge scl or posedge rst) begin
        if (rst) begin
            sda_drv_low <= 1'b0;
        end else if (state == hdrp_pkg::ST_IDLE
                     || state == hdrp_pkg::ST_IGNORE) begin
            sda_drv_low <= 1'b0;
        end else if (cnt == hdrp_pkg::CNT_ACK) begin
            sda_drv_low <= ack_pend;
        end else if (state == hdrp_pkg::ST_RDATA) begin
            sda_drv_low <= ~tx[bit_sel];
        end else begin
            sda_drv_low <= 1'b0;
        end
    end

    // open drain: only ever pull low; a pending stop releases at once
    assign sda_out = 1'b0;
    assign sda_oe  = sda_drv_low & ~stop_hit;

    ////////////////////////////////////////////////////////////////////////
    // crossings

    hdrp_sync u_wr_sync (
        .clk  (sys_clk),
        .rst  (rst),
        .din  (wr_tgl),
        .dout (wr_tgl_s)
    );

    hdrp_sync u_req_sync (
        .clk  (sys_clk),
        .rst  (rst),
        .din  (req_tgl),
        .dout (req_tgl_s)
    );

    hdrp_sync u_ack_sync (
        .clk  (scl),
        .rst  (rst),
        .din  (rd_ack_tgl),
        .dout (rd_ack_s)
    );

    // the held byte is only trusted once its answer toggle has landed
    assign rd_ready = (rd_ack_s == req_tgl);

    ////////////////////////////////////////////////////////////////////////
    // system domain: register writes

    // words stay put for a full byte time, so capture after sync is safe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_seen     <= 1'b0;
            reg_wr      <= 1'b0;
            reg_wr_addr <= hdrp_pkg::BYTE_RST;
            reg_wr_data <= hdrp_pkg::BYTE_RST;
        end else begin
            wr_seen <= wr_tgl_s;
            reg_wr  <= wr_tgl_s ^ wr_seen;
            if (wr_tgl_s ^ wr_seen) begin
                reg_wr_addr <= wr_addr;
                reg_wr_data <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system domain: read prefetch

    // a newer request simply overtakes an older one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_seen    <= 1'b0;
            reg_rd      <= 1'b0;
            reg_rd_addr <= hdrp_pkg::PTR_RST;
        end else begin
            req_seen <= req_tgl_s;
            reg_rd   <= req_tgl_s ^ req_seen;
            if (req_tgl_s ^ req_seen) begin
                reg_rd_addr <= req_addr;
            end
        end
    end

    // read data is taken the cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_hold    <= hdrp_pkg::BYTE_RST;
            rd_ack_tgl <= 1'b0;
        end else if (reg_rd) begin
            rd_hold    <= reg_rdata;
            rd_ack_tgl <= req_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_start_edge;
        start_hit;
    endsequence

    sequence s_addr_phase;
        state == hdrp_pkg::ST_ADDR && cnt == hdrp_pkg::CNT_FIRST;
    endsequence

    property p_start_frame;
        @(posedge scl) disable iff (rst)
        s_start_edge |=> s_addr_phase;
    endproperty
    a_start_frame: assert property (p_start_frame)
        else $error("start did not open an address phase");

    property p_byte_len;
        @(posedge scl) disable iff (rst)
        (s_addr_phase ##1 (!start_hit && !stop_hit) [*6])
            |=> cnt == hdrp_pkg::CNT_ACK;
    endproperty
    a_byte_len: assert property (p_byte_len)
        else $error("ack slot not after eight bits");

    property p_ack_slot;
        @(posedge scl) disable iff (rst)
        (cnt == hdrp_pkg::CNT_ACK && !start_hit && !stop_hit)
            |=> cnt == hdrp_pkg::CNT_RST;
    endproperty
    a_ack_slot: assert property (p_ack_slot)
        else $error("single ack bit not followed by new byte");

    property p_ack_drive;
        @(posedge scl) disable iff (rst)
        (cnt == hdrp_pkg::CNT_ACK && ack_pend && !stop_hit) |-> sda_oe;
    endproperty
    a_ack_drive: assert property (p_ack_drive)
        else $error("ack not pulled low");

    property p_foreign_addr;
        @(posedge scl) disable iff (rst)
        (state == hdrp_pkg::ST_ADDR && cnt == hdrp_pkg::CNT_LAST_BIT
         && !start_hit && !stop_hit
         && rx_byte[7:1] != hdrp_pkg::SLAVE_ADDR)
            |=> state == hdrp_pkg::ST_IGNORE ##1 !sda_oe;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr)
        else $error("foreign address not ignored");

    property p_own_addr_ack;
        @(posedge scl) disable iff (rst)
        (state == hdrp_pkg::ST_ADDR && cnt == hdrp_pkg::CNT_LAST_BIT
         && !start_hit && !stop_hit
         && rx_byte[7:1] == hdrp_pkg::SLAVE_ADDR)
            |=> ack_pend && (sda_oe || start_hit || stop_hit);
    endproperty
    a_own_addr_ack: assert property (p_own_addr_ack)
        else $error("own address not acknowledged");

    property p_wdata_step;
        @(posedge scl) disable iff (rst)
        (state == hdrp_pkg::ST_WDATA && cnt == hdrp_pkg::CNT_LAST_BIT
         && !start_hit && !stop_hit)
            |=> ptr == $past(ptr) + 8'h01 && ack_pend;
    endproperty
    a_wdata_step: assert property (p_wdata_step)
        else $error("write pointer did not advance or no ack");

    property p_nack_release;
        @(posedge scl) disable iff (rst)
        (state == hdrp_pkg::ST_RDATA && cnt == hdrp_pkg::CNT_ACK
         && sda_in && !start_hit && !stop_hit)
            |=> state == hdrp_pkg::ST_IGNORE && !sda_oe;
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("nack did not release sda");

    property p_wr_strobe;
        @(posedge sys_clk) disable iff (rst)
        reg_wr |=> !reg_wr;
    endproperty
    a_wr_strobe: assert property (p_wr_strobe)
        else $error("write strobe longer than one cycle");

    property p_rd_answer;
        @(posedge sys_clk) disable iff (rst)
        reg_rd |=> rd_hold == $past(reg_rdata) && rd_ack_tgl == req_seen;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read data not captured after strobe");

endmodule : hdrp_port

// ===== sim/hdrp_master.sv
`timescale 1ns/1ps

// host side of the two-wire link; scl stands high outside frames
module hdrp_master (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    localparam int HALF = 40;

    logic in_frame;

    // bus idle: scl driven high, sda released to the pull-up
    initial begin
        scl      = 1'b1;
        sda_low  = 1'b0;
        in_frame = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one clock: data set early in the low phase, sampled mid-high
    task automatic clk_bit(input logic b, output logic s);
        scl = 1'b0;
        #(HALF/4);
        sda_low = !b;
        #(HALF*3/4);
        scl = 1'b1;
        #(HALF/2);
        s = sda;
        #(HALF/2);
    endtask : clk_bit

    // a second start inside a frame becomes a repeated start
    task automatic start;
        if (in_frame) begin
            scl = 1'b0;
            #(HALF/4);
            sda_low = 1'b0;
            #(HALF*3/4);
            scl = 1'b1;
            #(HALF/2);
        end
        sda_low = 1'b1;
        #(HALF/2);
        in_frame = 1'b1;
    endtask : start

    task automatic stop;
        scl = 1'b0;
        #(HALF/4);
        sda_low = 1'b1;
        #(HALF*3/4);
        scl = 1'b1;
        #(HALF/2);
        sda_low = 1'b0;
        #(HALF/2);
        in_frame = 1'b0;
    endtask : stop

    // eight bits msb first, then the ack slot left to the target
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, ack);
    endtask : put_byte

    // nack only on the last byte of a read
    task automatic get_byte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b[i]);
        end
        clk_bit(nack, s);
    endtask : get_byte

endmodule : hdrp_master

// ===== sim/hdrp_port_tb.sv
`timescale 1ns/1ps

module hdrp_port_tb;
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] d0;
        logic [7:0] d1;
    } hdrp_row_type;

    logic       sys_clk;
    logic       rst;
    logic       scl;
    logic       m_low;
    logic       sda_out;
    logic       sda_oe;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wr_addr;
    logic [7:0] reg_wr_data;
    logic [7:0] reg_rd_addr;
    logic [7:0] reg_rdata;
    logic [7:0] regs [256];
    logic [7:0] b0;
    logic [7:0] b1;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    int         n_mismatch;
    int         n_checks;
    int         cycles;
    wire logic  sda_wire;

    // pointer 0xff makes the second byte wrap to register 0x00
    hdrp_row_type rows [4] = '{
        '{8'h03, 8'h12, 8'hA4}, '{8'h00, 8'h5A, 8'h81},
        '{8'h7E, 8'hFF, 8'h00}, '{8'hFF, 8'hC6, 8'h3C}};

    // wired-and with pull-up: high unless someone pulls low
    assign sda_wire = !(m_low || (sda_oe && !sda_out));

    hdrp_port uut (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .scl         (scl),
        .sda_in      (sda_wire),
        .sda_out     (sda_out),
        .sda_oe      (sda_oe),
        .reg_wr      (reg_wr),
        .reg_wr_addr (reg_wr_addr),
        .reg_wr_data (reg_wr_data),
        .reg_rd      (reg_rd),
        .reg_rd_addr (reg_rd_addr),
        .reg_rdata   (reg_rdata)
    );

    hdrp_master m (
        .scl     (scl),
        .sda_low (m_low),
        .sda     (sda_wire)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock, register file behind the port, hang guard
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (reg_wr) begin
            regs[reg_wr_addr] <= reg_wr_data;
        end
    end
    // address stands until the next request, so a plain lookup is enough
    assign reg_rdata = regs[reg_rd_addr];

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'h00;
        end
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk("idle_out", {5'h00, sda_oe, reg_wr, reg_rd}, 8'h00);
        chk("wr_addr_rst", reg_wr_addr, 8'h00);

        // table: two-byte write, then pointer write and two-byte read
        foreach (rows[i]) begin
            m.start();
            m.put_byte(8'hB4, a0);
            m.put_byte(rows[i].ptr, a1);
            m.put_byte(rows[i].d0, a2);
            m.put_byte(rows[i].d1, a3);
            m.stop();
            chk("wr_acks", {4'h0, a0, a1, a2, a3}, 8'h00);
            repeat (8) @(negedge sys_clk);
            chk("reg_first", regs[rows[i].ptr], rows[i].d0);
            chk("reg_next", regs[rows[i].ptr + 8'h01], rows[i].d1);
            m.start();
            m.put_byte(8'hB4, a0);
            m.put_byte(rows[i].ptr, a1);
            m.start();
            m.put_byte(8'hB5, a2);
            m.get_byte(b0, 1'b0);
            m.get_byte(b1, 1'b1);
            // device must have let go once scl fell after the nack
            fork
                m.stop();
                begin
                    #15;
                    chk("nack_release", {7'h00, sda_oe}, 8'h00);
                end
            join
            chk("rd_acks", {5'h00, a0, a1, a2}, 8'h00);
            chk("rd_first", b0, rows[i].d0);
            chk("rd_next", b1, rows[i].d1);
        end

        // foreign address: nothing acked, nothing written
        regs[8'h55] = 8'h00;
        m.start();
        m.put_byte(8'hB6, a0);
        m.put_byte(8'h55, a1);
        m.put_byte(8'h77, a2);
        m.stop();
        repeat (8) @(negedge sys_clk);
        chk("foreign_acks", {5'h00, a0, a1, a2}, 8'h07);
        chk("foreign_reg", regs[8'h55], 8'h00);

        // single data byte writes one register only
        regs[8'h11] = 8'h00;
        m.start();
        m.put_byte(8'hB4, a0);
        m.put_byte(8'h10, a1);
        m.put_byte(8'h99, a2);
        m.stop();
        repeat (8) @(negedge sys_clk);
        chk("single_acks", {5'h00, a0, a1, a2}, 8'h00);
        chk("single_reg", regs[8'h10], 8'h99);
        chk("single_next", regs[8'h11], 8'h00);
        chk("single_wr_addr", reg_wr_addr, 8'h10);
        chk("single_wr_data", reg_wr_data, 8'h99);
        chk("single_prefetch", reg_rd_addr, 8'h11);
        tally_and_finish();
    end

endmodule : hdrp_port_tb
